// ### common/emo_pkg.sv
package emo_pkg;

   // ------------------------------------------------------------
   // sizes and timing
   // ------------------------------------------------------------
   localparam int EMO_ADDR_W = 10;
   localparam int EMO_MEM_DEPTH = 1024;
   localparam logic [1:0] EMO_SKIP_CYCLES = 2'h3;
   localparam logic [7:0] EMO_ALL_ONES = 8'hff;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [4:0] EMO_OFS_CMD = 5'h00;
   localparam logic [4:0] EMO_OFS_ADDR = 5'h04;
   localparam logic [4:0] EMO_OFS_ACC = 5'h08;
   localparam logic [4:0] EMO_OFS_FLAGS = 5'h0c;
   localparam logic [4:0] EMO_OFS_MDATA = 5'h10;
   localparam logic [4:0] EMO_OFS_STATUS = 5'h14;
   localparam logic [4:0] EMO_OFS_PC = 5'h18;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int EMO_CMD_OP_LSB = 0;
   localparam int EMO_CMD_BIT_LSB = 8;
   localparam int EMO_STAT_BUSY = 0;
   localparam int EMO_STAT_SKIP = 1;
   localparam int EMO_STAT_SQUASHED = 2;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] EMO_ACC_RST = 8'h00;
   localparam logic [15:0] EMO_PC_RST = 16'h0000;
   localparam logic [EMO_ADDR_W-1:0] EMO_ADDR_RST = 10'h000;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      dec_mem_to_acc, inc_mem_in_place, inc_mem_to_acc,
      ext_move_to_acc, ext_move_to_mem,
      or_mem_into_acc, or_acc_into_mem,
      rotate_left_mem, rotate_left_to_acc,
      rotate_left_carry_mem, rotate_left_carry_to_acc,
      rotate_right_mem, rotate_right_to_acc,
      rotate_right_carry_mem, rotate_right_carry_to_acc,
      sub_borrow_to_acc, sub_borrow_to_mem,
      dec_skip_if_zero, dec_to_acc_skip_if_zero, inc_skip_if_zero,
      set_ones, set_bit
   } emo_op_t;

   // flags register layout, bit 0 is carry
   typedef struct packed {
      logic [1:0] unused;
      logic carry_zero_chain_flag;
      logic signed_compare_flag;
      logic sign_wrap_flag;
      logic zero_flag;
      logic low_nibble_carry_flag;
      logic carry_flag;
   } emo_flags_t;

   typedef struct packed {
      emo_op_t op;
      logic [2:0] bit_sel;
   } emo_instr_t;

   typedef struct packed {
      logic [7:0] value;
      logic to_acc;
      logic to_mem;
      emo_flags_t flags;
      logic is_skip;
      logic skip;
   } emo_alu_res_t;

endpackage

// ### verilog/emo_alu.sv
`timescale 1ns/1ps
module emo_alu
   import emo_pkg::*;
(
   // operands
   input wire emo_instr_t instr_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] mem_i,
   input wire emo_flags_t flags_i,
   // result
   output emo_alu_res_t res_o
);

   // ------------------------------------------------------------
   // shared arithmetic
   // ------------------------------------------------------------
   wire logic [7:0] dec_val = mem_i - 8'h01;
   wire logic [7:0] inc_val = mem_i + 8'h01;
   wire logic borrow_in = ~flags_i.carry_flag;
   wire logic [8:0] sub_full = {1'b0, acc_i} - {1'b0, mem_i} - {8'h00, borrow_in};
   wire logic [4:0] sub_low = {1'b0, acc_i[3:0]} - {1'b0, mem_i[3:0]} - {4'h0, borrow_in};
   wire logic [7:0] sub_val = sub_full[7:0];
   wire logic sub_wrap = (acc_i[7] ^ mem_i[7]) & (acc_i[7] ^ sub_val[7]);
   wire logic sub_z = (sub_val == 8'h00);
   wire logic [7:0] bit_mask = 8'h01 << instr_i.bit_sel;

   always_comb begin
      res_o = '0;
      res_o.flags = flags_i;
      unique case (instr_i.op)
         dec_mem_to_acc: begin
            res_o.value = dec_val;
            res_o.to_acc = 1'b1;
            res_o.flags.zero_flag = (dec_val == 8'h00);
         end
         inc_mem_in_place, inc_mem_to_acc: begin
            res_o.value = inc_val;
            res_o.to_acc = (instr_i.op == inc_mem_to_acc);
            res_o.to_mem = (instr_i.op == inc_mem_in_place);
            res_o.flags.zero_flag = (inc_val == 8'h00);
         end
         ext_move_to_acc: begin
            res_o.value = mem_i;
            res_o.to_acc = 1'b1;
         end
         ext_move_to_mem: begin
            res_o.value = acc_i;
            res_o.to_mem = 1'b1;
         end
         or_mem_into_acc, or_acc_into_mem: begin
            res_o.value = acc_i | mem_i;
            res_o.to_acc = (instr_i.op == or_mem_into_acc);
            res_o.to_mem = (instr_i.op == or_acc_into_mem);
            res_o.flags.zero_flag = ((acc_i | mem_i) == 8'h00);
         end
         rotate_left_mem, rotate_left_to_acc: begin
            res_o.value = {mem_i[6:0], mem_i[7]};
            res_o.to_acc = (instr_i.op == rotate_left_to_acc);
            res_o.to_mem = (instr_i.op == rotate_left_mem);
         end
         rotate_left_carry_mem, rotate_left_carry_to_acc: begin
            res_o.value = {mem_i[6:0], flags_i.carry_flag};
            res_o.flags.carry_flag = mem_i[7];
            res_o.to_acc = (instr_i.op == rotate_left_carry_to_acc);
            res_o.to_mem = (instr_i.op == rotate_left_carry_mem);
         end
         rotate_right_mem, rotate_right_to_acc: begin
            res_o.value = {mem_i[0], mem_i[7:1]};
            res_o.to_acc = (instr_i.op == rotate_right_to_acc);
            res_o.to_mem = (instr_i.op == rotate_right_mem);
         end
         rotate_right_carry_mem, rotate_right_carry_to_acc: begin
            res_o.value = {flags_i.carry_flag, mem_i[7:1]};
            res_o.flags.carry_flag = mem_i[0];
            res_o.to_acc = (instr_i.op == rotate_right_carry_to_acc);
            res_o.to_mem = (instr_i.op == rotate_right_carry_mem);
         end
         sub_borrow_to_acc, sub_borrow_to_mem: begin
            res_o.value = sub_val;
            res_o.to_acc = (instr_i.op == sub_borrow_to_acc);
            res_o.to_mem = (instr_i.op == sub_borrow_to_mem);
            res_o.flags.carry_flag = ~sub_full[8];
            res_o.flags.low_nibble_carry_flag = ~sub_low[4];
            res_o.flags.zero_flag = sub_z;
            res_o.flags.sign_wrap_flag = sub_wrap;
            res_o.flags.signed_compare_flag = ~(sub_wrap ^ sub_val[7]);
            // zero chained over multi-byte subtracts
            res_o.flags.carry_zero_chain_flag = sub_z & flags_i.carry_zero_chain_flag;
         end
         dec_skip_if_zero, dec_to_acc_skip_if_zero: begin
            res_o.value = dec_val;
            res_o.to_acc = (instr_i.op == dec_to_acc_skip_if_zero);
            res_o.to_mem = (instr_i.op == dec_skip_if_zero);
            res_o.is_skip = 1'b1;
            res_o.skip = (dec_val == 8'h00);
         end
         inc_skip_if_zero: begin
            res_o.value = inc_val;
            res_o.to_mem = 1'b1;
            res_o.is_skip = 1'b1;
            res_o.skip = (inc_val == 8'h00);
         end
         set_ones: begin
            res_o.value = EMO_ALL_ONES;
            res_o.to_mem = 1'b1;
         end
         set_bit: begin
            res_o.value = mem_i | bit_mask;
            res_o.to_mem = 1'b1;
         end
         // undefined opcode codes fall through as a no-op
         default: begin
            res_o.value = 8'h00;
         end
      endcase
   end

endmodule // emo_alu

// ### verilog/emo_datapath.sv
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module emo_datapath
   import emo_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // avalon-mm slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // status
   output logic busy_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {st_idle, st_exec, st_dummy} emo_state_t;

   emo_state_t state;
   emo_instr_t instr;
   emo_flags_t flags;
   emo_alu_res_t alu_res;
   logic [7:0] mem [EMO_MEM_DEPTH];
   logic [7:0] acc;
   logic [EMO_ADDR_W-1:0] addr;
   logic [15:0] pc;
   logic [1:0] dummy_cnt;
   logic skip_pend;
   logic squashed;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire logic req = avs_read_i | avs_write_i;
   wire logic busy = (state != st_idle);
   // writes wait for the instruction to finish so that the bus never
   // races the datapath for the accumulator, flags or memory port
   wire logic stall = avs_write_i & busy;
   wire logic accept = req & avs_waitrequest_o & ~stall;
   wire logic wr = accept & avs_write_i;
   wire logic lane0 = avs_byteenable_i[0];
   wire logic lane1 = avs_byteenable_i[1];
   wire logic hit_cmd = (avs_address_i == EMO_OFS_CMD);
   wire logic hit_addr = (avs_address_i == EMO_OFS_ADDR);
   wire logic hit_acc = (avs_address_i == EMO_OFS_ACC);
   wire logic hit_flags = (avs_address_i == EMO_OFS_FLAGS);
   wire logic hit_mdata = (avs_address_i == EMO_OFS_MDATA);
   wire logic hit_status = (avs_address_i == EMO_OFS_STATUS);
   wire logic hit_pc = (avs_address_i == EMO_OFS_PC);
   wire logic start = wr & hit_cmd & lane0;
   wire emo_instr_t cmd_instr = '{
      op: emo_op_t'(avs_writedata_i[EMO_CMD_OP_LSB +: 5]),
      bit_sel: avs_writedata_i[EMO_CMD_BIT_LSB +: 3]
   };
   wire logic [7:0] mem_rd = mem[addr];

   wire logic [31:0] status_word = {29'h0, squashed, skip_pend, busy};
   wire logic [31:0] cmd_word = {21'h0, instr.bit_sel, 3'h0, instr.op};
   wire logic [31:0] rd_word =
      hit_cmd ? cmd_word :
      hit_addr ? {22'h0, addr} :
      hit_acc ? {24'h0, acc} :
      hit_flags ? {24'h0, flags} :
      hit_mdata ? {24'h0, mem_rd} :
      hit_status ? status_word :
      hit_pc ? {16'h0, pc} :
      32'h0;

   // ------------------------------------------------------------
   // execution
   // ------------------------------------------------------------
   emo_alu u_alu (
      .instr_i(instr),
      .acc_i(acc),
      .mem_i(mem_rd),
      .flags_i(flags),
      .res_o(alu_res)
   );

   wire logic exec = (state == st_exec);
   wire logic live = exec & ~skip_pend;
   wire logic do_acc = live & alu_res.to_acc;
   wire logic do_mem = live & alu_res.to_mem;
   wire logic go_dummy = live & alu_res.is_skip;
   wire logic bus_mem_wr = wr & hit_mdata & lane0;

   emo_state_t next_state;
   assign next_state = start ? st_exec :
                       go_dummy ? st_dummy :
                       (state == st_dummy && dummy_cnt != 2'h0) ? st_dummy :
                       st_idle;

   // ------------------------------------------------------------
   // bus answer
   // ------------------------------------------------------------
   // waitrequest rests high; a taken request drops it for one cycle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
      end else begin
         avs_waitrequest_o <= ~accept;
         if (accept && avs_read_i) begin
            avs_readdata_o <= rd_word;
         end
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state <= st_idle;
         busy_o <= 1'b0;
         instr <= '{op: dec_mem_to_acc, bit_sel: 3'h0};
         dummy_cnt <= 2'h0;
         pc <= EMO_PC_RST;
         skip_pend <= 1'b0;
         squashed <= 1'b0;
      end else begin
         state <= next_state;
         busy_o <= (next_state != st_idle);
         if (start) begin
            instr <= cmd_instr;
         end
         // one instruction slot is spent on the skip itself, the rest are dummies
         if (go_dummy) begin
            dummy_cnt <= EMO_SKIP_CYCLES - 2'h2;
         end else if (state == st_dummy && dummy_cnt != 2'h0) begin
            dummy_cnt <= dummy_cnt - 2'h1;
         end
         if (exec) begin
            pc <= pc + 16'h0001;
            squashed <= skip_pend;
            skip_pend <= live & alu_res.skip;
         end
      end
   end

   // ------------------------------------------------------------
   // accumulator, flags, address
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         acc <= EMO_ACC_RST;
         flags <= '0;
         addr <= EMO_ADDR_RST;
      end else begin
         if (do_acc) begin
            acc <= alu_res.value;
         end else if (wr && hit_acc && lane0) begin
            acc <= avs_writedata_i[7:0];
         end
         // skip instructions never touch the flags
         if (live && !alu_res.is_skip) begin
            flags <= alu_res.flags;
         end else if (wr && hit_flags && lane0) begin
            flags <= {2'b00, avs_writedata_i[5:0]};
         end
         if (wr && hit_addr) begin
            if (lane0) begin
               addr[7:0] <= avs_writedata_i[7:0];
            end
            if (lane1) begin
               addr[EMO_ADDR_W-1:8] <= avs_writedata_i[EMO_ADDR_W-1:8];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // data memory, not reset
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (do_mem) begin
         mem[addr] <= alu_res.value;
      end else if (bus_mem_wr) begin
         mem[addr] <= avs_writedata_i[7:0];
      end
   end

endmodule // emo_datapath

// ### bench/emo_datapath_asserts.sv
`timescale 1ns/1ps
module emo_datapath_asserts
   import emo_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // avalon-mm slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // status
   input wire logic busy_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------
   // instruction issue
   // ------------------------------------------------------------
   wire cmd_done = avs_write_i && !avs_waitrequest_o && avs_address_i == EMO_OFS_CMD;
   wire skip_op = avs_writedata_i[4:0] inside {5'h11, 5'h12, 5'h13};
   sequence s_skip_cmd;
      cmd_done && skip_op;
   endsequence
   sequence s_three_slots;
      busy_o [*3] ##1 !busy_o;
   endsequence
   a_skip_three: assert property (s_skip_cmd |-> s_three_slots)
      else $error("skip instruction did not take three slots");
   a_single_slot: assert property (cmd_done && !skip_op |-> busy_o ##1 !busy_o)
      else $error("plain instruction busy length wrong");
   a_busy_cause: assert property ($rose(busy_o) |-> $past(avs_write_i) && $past(avs_address_i) == EMO_OFS_CMD)
      else $error("busy rose without a command write");
   a_write_stall: assert property (avs_write_i && busy_o |=> avs_waitrequest_o)
      else $error("write answered while busy");
   // ------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------
   a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low longer than one cycle");
   a_read_prompt: assert property ($rose(avs_read_i) |=> !avs_waitrequest_o)
      else $error("read not answered after one wait cycle");
   a_answer_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i) || $past(avs_write_i))
      else $error("answer without a request");
   a_rdata_hold: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");
   a_reset_idle: assert property ($past(rst_i) |-> avs_waitrequest_o && !busy_o && avs_readdata_o == 32'h0)
      else $error("outputs not idle after reset");
   c_skip: cover property (s_skip_cmd);
endmodule // emo_datapath_asserts

bind emo_datapath emo_datapath_asserts u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));

// ### bench/tb_emo_datapath.sv
`timescale 1ns/1ps
module tb_emo_datapath;
   import emo_pkg::*;
   logic clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, busy_o;
   logic [4:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, q;
   logic [3:0] avs_byteenable_i;
   logic [7:0] acc_set [3] = '{8'h5a, 8'h00, 8'h80};
   logic [7:0] mem_set [3] = '{8'h01, 8'hff, 8'h01};
   logic [5:0] flg_set [3] = '{6'h3f, 6'h20, 6'h21};
   logic [4:0] rst_ofs [6] = '{5'h04, 5'h08, 5'h0c, 5'h14, 5'h18, 5'h1c};
   int err_total = 0, compares = 0, cycles = 0;

   emo_datapath dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // ------------------------------------------------------------
   // bus access and checking
   // ------------------------------------------------------------
   // one edge passes first so a released strobe is never raised in the same step
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd);
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      avs_writedata_i <= d;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // reference: {skip, flags, acc, mem}
   // ------------------------------------------------------------
   function automatic logic [22:0] ref_op(input logic [4:0] op, input logic [2:0] b, input logic [7:0] a,
      input logic [7:0] m, input logic [5:0] f);
      logic [8:0] r;
      logic [4:0] h;
      logic c;
      logic sk;
      c = f[0];
      sk = 1'b0;
      case (op)
         5'h00: begin a = m - 8'h01; f[2] = (a == 8'h00); end
         5'h01: begin m = m + 8'h01; f[2] = (m == 8'h00); end
         5'h02: begin a = m + 8'h01; f[2] = (a == 8'h00); end
         5'h03: a = m;
         5'h04: m = a;
         5'h05: begin a = a | m; f[2] = (a == 8'h00); end
         5'h06: begin m = a | m; f[2] = (m == 8'h00); end
         5'h07: m = {m[6:0], m[7]};
         5'h08: a = {m[6:0], m[7]};
         5'h09: begin f[0] = m[7]; m = {m[6:0], c}; end
         5'h0a: begin f[0] = m[7]; a = {m[6:0], c}; end
         5'h0b: m = {m[0], m[7:1]};
         5'h0c: a = {m[0], m[7:1]};
         5'h0d: begin f[0] = m[0]; m = {c, m[7:1]}; end
         5'h0e: begin f[0] = m[0]; a = {c, m[7:1]}; end
         5'h0f, 5'h10: begin
            r = {1'b0, a} - {1'b0, m} - {8'h00, !c};
            h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, !c};
            f[0] = !r[8];
            f[1] = !h[4];
            f[2] = (r[7:0] == 8'h00);
            f[3] = (a[7] != m[7]) && (r[7] != a[7]);
            f[4] = !(f[3] ^ r[7]);
            f[5] = f[2] & f[5];
            if (op == 5'h0f) a = r[7:0];
            else m = r[7:0];
         end
         5'h11: begin m = m - 8'h01; sk = (m == 8'h00); end
         5'h12: begin a = m - 8'h01; sk = (a == 8'h00); end
         5'h13: begin m = m + 8'h01; sk = (m == 8'h00); end
         5'h14: m = 8'hff;
         5'h15: m[b] = 1'b1;
         default: ;
      endcase
      return {sk, f, a, m};
   endfunction

   // load operands, issue, check busy_o, then rewrite the address once idle and read back the results
   task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [9:0] ad, input int s);
      logic [22:0] e;
      logic [31:0] rd;
      logic [31:0] p;
      e = ref_op(op, b, acc_set[s], mem_set[s], flg_set[s]);
      bus(1'b1, EMO_OFS_ADDR, {22'h0, ad}, rd);
      bus(1'b1, EMO_OFS_MDATA, {24'h0, mem_set[s]}, rd);
      bus(1'b1, EMO_OFS_ACC, {24'h0, acc_set[s]}, rd);
      bus(1'b1, EMO_OFS_FLAGS, {26'h0, flg_set[s]}, rd);
      bus(1'b1, EMO_OFS_CMD, {21'h0, b, 3'h0, op}, rd);
      chk("busy_o", {31'h0, busy_o}, 32'h1);
      // a skip is still in its dummy slots when this read is taken
      if (op inside {5'h11, 5'h12, 5'h13}) begin
         bus(1'b0, EMO_OFS_STATUS, 32'h0, rd);
         chk("skip_busy", rd, {30'h0, e[22], 1'b1});
      end
      bus(1'b1, EMO_OFS_ADDR, {22'h0, ad}, rd);
      bus(1'b0, EMO_OFS_ACC, 32'h0, rd);
      chk("acc", rd, {24'h0, e[15:8]});
      bus(1'b0, EMO_OFS_MDATA, 32'h0, rd);
      chk("mem", rd, {24'h0, e[7:0]});
      bus(1'b0, EMO_OFS_FLAGS, 32'h0, rd);
      chk("flags", rd, {26'h0, e[21:16]});
      bus(1'b0, EMO_OFS_STATUS, 32'h0, rd);
      chk("status", rd, {30'h0, e[22], 1'b0});
      if (e[22]) begin
         bus(1'b0, EMO_OFS_PC, 32'h0, p);
         bus(1'b1, EMO_OFS_CMD, 32'h14, rd);
         bus(1'b0, EMO_OFS_STATUS, 32'h0, rd);
         chk("squashed", rd, 32'h4);
         bus(1'b0, EMO_OFS_PC, 32'h0, rd);
         chk("pc", rd, p + 32'h1);
         bus(1'b0, EMO_OFS_MDATA, 32'h0, rd);
         chk("mem_squash", rd, {24'h0, e[7:0]});
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 5'h00;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'hf;
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      // unmapped offset 1c must swallow the write and read back zero
      bus(1'b1, 5'h1c, 32'hffffffff, q);
      foreach (rst_ofs[k]) begin
         bus(1'b0, rst_ofs[k], 32'h0, q);
         chk("reset_value", q, 32'h0);
      end
      $display("test reset done");
      for (int s = 0; s < 3; s++) begin
         for (int i = 0; i < 23; i++) begin
            run((i == 22) ? 5'h1f : i[4:0], i[2:0], {i[4:0], s[1:0], 3'h5}, s);
         end
         $display("test operand set %0d done", s);
      end
      end_of_test();
   end

   // a hung handshake ends the run as a failure
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end
endmodule // tb_emo_datapath
